// ### hdl/ptc_defs.svh
//********************************************************************
// Behaviour
// - PWM period equals period value, zero means 1024
// - Duty at or above period gives full duty
// - PWM counting continues while output forced
// - Clear-select bit ignored, period always clears PWM
// - Run rise clears counter and starts pulse
// - External clock pin rising edge sets run bit in pulse mode
// - Compare A match clears run, ends pulse
// - Compare A match raises interrupt in pulse mode
// - Pulse counter clears only on run rise
// - Capture source select, timer 0 comparator option
// - Edge select: rise, fall, both, or none
// - Capture edge latches counter, raises interrupt
// - Capture counter free-runs, period match clears it
// - Period zero lets counter reach maximum
// - Timer 0 extra clear sources by edge
// - Clear field set sends falling-edge captures to B
// - Capture pulses under one clock may drop
// - Timers 1 and 2 capture into A only
// - Capture mode drives no output
// - PWM duty, active level, force and polarity
// - Counter and compare values ten bits wide
//********************************************************************
`ifndef PTC_DEFS_SVH
`define PTC_DEFS_SVH

`define PTC_CNT_W 10
`define PTC_FULL_PERIOD 11'h400
`define PTC_MODE_COMPARE 2'h0
`define PTC_MODE_CAPTURE 2'h1
`define PTC_MODE_PWM 2'h2
`define PTC_MODE_TIMER 2'h3
`define PTC_IO_RISE 2'h0
`define PTC_IO_FALL 2'h1
`define PTC_IO_BOTH 2'h2
`define PTC_IO_NONE 2'h3
`define PTC_IO_FORCE_OFF 2'h0
`define PTC_IO_FORCE_ON 2'h1
`define PTC_IO_SINGLE 2'h3
`define PTC_CLR_NONE 2'h0
`define PTC_CLR_RISE 2'h1
`define PTC_CLR_FALL 2'h2
`define PTC_CLR_BOTH 2'h3
`define PTC_SRC_COMPARATOR 2'h1

`endif

// ### hdl/ptc_pkg.sv
`include "ptc_defs.svh"

package ptc_pkg;

  typedef enum logic [1:0] {
    PTC_COMPARE = `PTC_MODE_COMPARE,
    PTC_CAPTURE = `PTC_MODE_CAPTURE,
    PTC_PWM = `PTC_MODE_PWM,
    PTC_TIMER = `PTC_MODE_TIMER
  } ptc_mode_t;

endpackage

// ### hdl/ptc_capture_store.sv
`timescale 1ns/1ns

module ptc_capture_store #(
  parameter int W = 10
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // Software writes
  input wire logic i_sw_wr_a,
  input wire logic i_sw_wr_b,
  input wire logic [W-1:0] i_sw_data,
  // Capture writes
  input wire logic i_cap_wr,
  input wire logic i_cap_sel_b,
  input wire logic [W-1:0] i_cap_data,
  // Stored values
  output logic [W-1:0] o_value_a,
  output logic [W-1:0] o_value_b
);

  logic [W-1:0] value_a_ff;
  logic [W-1:0] value_b_ff;
  logic [W-1:0] nxt_value_a;
  logic [W-1:0] nxt_value_b;

  // Capture has priority over a software write in the same cycle
  always_comb begin
    nxt_value_a = value_a_ff;
    nxt_value_b = value_b_ff;
    if (i_sw_wr_a) begin
      nxt_value_a = i_sw_data;
    end
    if (i_sw_wr_b) begin
      nxt_value_b = i_sw_data;
    end
    if (i_cap_wr && !i_cap_sel_b) begin
      nxt_value_a = i_cap_data;
    end else if (i_cap_wr && i_cap_sel_b) begin
      nxt_value_b = i_cap_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      value_a_ff <= '0;
      value_b_ff <= '0;
    end else begin
      value_a_ff <= nxt_value_a;
      value_b_ff <= nxt_value_b;
    end
  end

  assign o_value_a = value_a_ff;
  assign o_value_b = value_b_ff;

endmodule // ptc_capture_store

// ### hdl/ptc_timer.sv
`timescale 1ns/1ns
`include "ptc_defs.svh"

module ptc_timer #(
  parameter bit IS_TIMER0 = 1'b1,
  parameter int CNT_W = `PTC_CNT_W
) (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESETN,
  // Selected timer clock, one-cycle tick
  input wire logic I_TIMER_TICK,
  // Control bits
  input wire ptc_pkg::ptc_mode_t I_MODE_SELECT,
  input wire logic [1:0] I_OUTPUT_CTRL,
  input wire logic I_COUNTER_RUN_WR,
  input wire logic I_COUNTER_RUN_WDATA,
  input wire logic I_COUNTER_CLEAR_SELECT,
  input wire logic I_OUTPUT_INITIAL_LEVEL,
  input wire logic I_OUTPUT_POLARITY,
  input wire logic I_CAPTURE_SOURCE_SELECT,
  input wire logic [1:0] I_INPUT_SOURCE_SELECT,
  input wire logic [1:0] I_CAPTURE_CLEAR,
  // Compare values
  input wire logic [CNT_W-1:0] I_PERIOD_COMPARE_VALUE,
  input wire logic I_COMPARE_A_WR,
  input wire logic I_COMPARE_B_WR,
  input wire logic [CNT_W-1:0] I_COMPARE_WDATA,
  // Capture and trigger inputs
  input wire logic I_EXT_TIMER_CLOCK_PIN,
  input wire logic I_CAPTURE_INPUT_PIN,
  input wire logic I_COMPARATOR_CAPTURE_SIGNAL,
  // Status
  output logic O_COUNTER_RUN,
  output logic [CNT_W-1:0] O_COUNTER_VALUE,
  output logic [CNT_W-1:0] O_COMPARE_A_VALUE,
  output logic [CNT_W-1:0] O_COMPARE_B_VALUE,
  output logic O_CAPTURE_LEVEL_FLAG,
  output logic O_INT_A,
  output logic O_INT_P,
  // Timer output pin
  output logic O_TIMER_OUT,
  output logic O_TIMER_OUT_OE_N
);

  //******************************************************************
  // Functions
  //******************************************************************
  function automatic logic edge_hit(input logic on_rise,
                                    input logic on_fall,
                                    input logic rise,
                                    input logic fall);
    edge_hit = (on_rise && rise) || (on_fall && fall);
  endfunction

  //******************************************************************
  // Input synchronisers
  //******************************************************************
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [2:0] nxt_sync1;
  logic [2:0] nxt_sync2;

  always_comb begin
    nxt_sync1 = {I_COMPARATOR_CAPTURE_SIGNAL, I_CAPTURE_INPUT_PIN,
                 I_EXT_TIMER_CLOCK_PIN};
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  //******************************************************************
  // Mode decode and edges
  //******************************************************************
  logic pwm_mode;
  logic sp_mode;
  logic cap_mode;
  logic pin_src;
  logic cap_src;
  logic ext_rise;
  logic cap_rise;
  logic cap_fall;
  logic cap_fire;
  logic cap_to_b;
  logic clr_hit;
  logic run_rise;
  logic [CNT_W-1:0] cnt_inc;
  logic [CNT_W:0] period_eff;
  logic duty_on;
  logic full_duty;
  logic act_lvl;
  logic ext_prev_ff;
  logic cap_prev_ff;
  logic run_ff;
  logic run_d_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] compare_a_value;

  assign pwm_mode = I_MODE_SELECT == ptc_pkg::PTC_PWM
                    && I_OUTPUT_CTRL != `PTC_IO_SINGLE;
  assign sp_mode = I_MODE_SELECT == ptc_pkg::PTC_PWM
                   && I_OUTPUT_CTRL == `PTC_IO_SINGLE;
  assign cap_mode = I_MODE_SELECT == ptc_pkg::PTC_CAPTURE;

  // Comparator source exists on timer 0 only
  assign pin_src = (IS_TIMER0
                    && I_INPUT_SOURCE_SELECT == `PTC_SRC_COMPARATOR)
                   ? sync2_ff[2] : sync2_ff[1];
  assign cap_src = I_CAPTURE_SOURCE_SELECT ? sync2_ff[0] : pin_src;

  // Edges on the synchronised level; short pulses may vanish here
  assign ext_rise = sync2_ff[0] && !ext_prev_ff;
  assign cap_rise = cap_src && !cap_prev_ff;
  assign cap_fall = !cap_src && cap_prev_ff;

  assign cap_fire = cap_mode && run_ff
                    && edge_hit(I_OUTPUT_CTRL == `PTC_IO_RISE
                                || I_OUTPUT_CTRL == `PTC_IO_BOTH,
                                I_OUTPUT_CTRL == `PTC_IO_FALL
                                || I_OUTPUT_CTRL == `PTC_IO_BOTH,
                                cap_rise, cap_fall);
  assign clr_hit = IS_TIMER0 && cap_mode && run_ff
                   && edge_hit(I_CAPTURE_CLEAR == `PTC_CLR_RISE
                               || I_CAPTURE_CLEAR == `PTC_CLR_BOTH,
                               I_CAPTURE_CLEAR == `PTC_CLR_FALL
                               || I_CAPTURE_CLEAR == `PTC_CLR_BOTH,
                               cap_rise, cap_fall);
  // Falling captures go to B once a clear source is set
  assign cap_to_b = IS_TIMER0 && I_CAPTURE_CLEAR != `PTC_CLR_NONE
                    && cap_fall;

  assign run_rise = run_ff && !run_d_ff;
  assign cnt_inc = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
  assign period_eff = (I_PERIOD_COMPARE_VALUE == '0) ? `PTC_FULL_PERIOD
                      : {1'b0, I_PERIOD_COMPARE_VALUE};
  assign full_duty = {1'b0, compare_a_value} >= period_eff;
  assign duty_on = full_duty || cnt_ff < compare_a_value;
  assign act_lvl = I_OUTPUT_INITIAL_LEVEL ^ I_OUTPUT_POLARITY;

  //******************************************************************
  // Counter, run bit and events
  //******************************************************************
  logic int_a_ff;
  logic int_p_ff;
  logic out_ff;
  logic oe_n_ff;
  logic flag_ff;
  logic nxt_run;
  logic nxt_int_a;
  logic nxt_int_p;
  logic nxt_out;
  logic nxt_oe_n;
  logic nxt_flag;
  logic [CNT_W-1:0] nxt_cnt;
  logic a_match;
  logic p_match;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_run = run_ff;
    a_match = 1'b0;
    p_match = 1'b0;
    if (I_COUNTER_RUN_WR) begin
      nxt_run = I_COUNTER_RUN_WDATA;
    end
    if (run_rise) begin
      nxt_cnt = '0;
    end else if (clr_hit) begin
      nxt_cnt = '0;
    end else if (run_ff && I_TIMER_TICK) begin
      nxt_cnt = cnt_inc;
      if (sp_mode) begin
        a_match = cnt_inc == compare_a_value;
      end else begin
        a_match = cnt_inc == compare_a_value;
        // Period match clears; the clear-select bit is ignored
        if (cnt_inc == I_PERIOD_COMPARE_VALUE) begin
          p_match = 1'b1;
          nxt_cnt = '0;
        end
      end
    end
    if (sp_mode && a_match) begin
      nxt_run = 1'b0;
    end
    if (sp_mode && ext_rise) begin
      nxt_run = 1'b1;
    end
    nxt_int_a = (a_match && !cap_mode) || cap_fire;
    nxt_int_p = p_match;
    nxt_flag = cap_fire ? cap_src : flag_ff;
  end

  // Output pin: PWM logic runs for every output control setting except single pulse
  always_comb begin
    nxt_out = 1'b0;
    nxt_oe_n = 1'b1;
    if (pwm_mode) begin
      nxt_oe_n = 1'b0;
      if (I_OUTPUT_CTRL == `PTC_IO_FORCE_OFF) begin
        nxt_out = !act_lvl;
      end else if (I_OUTPUT_CTRL == `PTC_IO_FORCE_ON) begin
        nxt_out = act_lvl;
      end else begin
        nxt_out = duty_on ? act_lvl : !act_lvl;
      end
    end else if (sp_mode) begin
      nxt_oe_n = 1'b0;
      nxt_out = run_ff ? act_lvl : !act_lvl;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
      run_d_ff <= 1'b0;
      ext_prev_ff <= 1'b0;
      cap_prev_ff <= 1'b0;
      int_a_ff <= 1'b0;
      int_p_ff <= 1'b0;
      out_ff <= 1'b0;
      oe_n_ff <= 1'b1;
      flag_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
      run_d_ff <= run_ff;
      ext_prev_ff <= sync2_ff[0];
      cap_prev_ff <= cap_src;
      int_a_ff <= nxt_int_a;
      int_p_ff <= nxt_int_p;
      out_ff <= nxt_out;
      oe_n_ff <= nxt_oe_n;
      flag_ff <= nxt_flag;
    end
  end

  //******************************************************************
  // Compare and capture store
  //******************************************************************
  logic [CNT_W-1:0] compare_b_value;

  ptc_capture_store #(
    .W(CNT_W)
  ) u_store (
    .i_clock(I_CLOCK),
    .i_resetn(I_RESETN),
    .i_sw_wr_a(I_COMPARE_A_WR),
    .i_sw_wr_b(I_COMPARE_B_WR && IS_TIMER0),
    .i_sw_data(I_COMPARE_WDATA),
    .i_cap_wr(cap_fire),
    .i_cap_sel_b(cap_to_b),
    .i_cap_data(cnt_ff),
    .o_value_a(compare_a_value),
    .o_value_b(compare_b_value)
  );

  assign O_COUNTER_RUN = run_ff;
  assign O_COUNTER_VALUE = cnt_ff;
  assign O_COMPARE_A_VALUE = compare_a_value;
  assign O_COMPARE_B_VALUE = compare_b_value;
  assign O_CAPTURE_LEVEL_FLAG = flag_ff;
  assign O_INT_A = int_a_ff;
  assign O_INT_P = int_p_ff;
  assign O_TIMER_OUT = out_ff;
  assign O_TIMER_OUT_OE_N = oe_n_ff;

  //******************************************************************
  // Assertions
  //******************************************************************
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESETN);

  sequence s_full_pwm;
    (pwm_mode && I_OUTPUT_CTRL[1] && full_duty) ##1
      (pwm_mode && I_OUTPUT_CTRL[1] && full_duty);
  endsequence

  sequence s_sp_start;
    sp_mode && run_rise;
  endsequence

  a_pwm_period_clear: assert property (
    pwm_mode && run_ff && !run_rise && I_TIMER_TICK
    && cnt_inc == I_PERIOD_COMPARE_VALUE |=> cnt_ff == '0 && O_INT_P)
    else $error("pwm counter not cleared on period match");
  a_pwm_full_duty: assert property (
    s_full_pwm |-> O_TIMER_OUT == $past(act_lvl))
    else $error("full duty output not active");
  a_sp_start_zero: assert property (
    s_sp_start |=> cnt_ff == '0 ##0 O_TIMER_OUT == $past(act_lvl))
    else $error("single pulse start wrong");
  a_sp_ext_set: assert property (
    sp_mode && ext_rise |=> run_ff)
    else $error("external edge did not set run");
  a_sp_match_stop: assert property (
    sp_mode && a_match && !ext_rise |=> !run_ff && O_INT_A)
    else $error("compare A match did not end pulse");
  a_cap_latch_a: assert property (
    cap_fire && !cap_to_b |=> O_COMPARE_A_VALUE == $past(cnt_ff)
    && O_INT_A)
    else $error("capture not latched into A");
  a_cap_none: assert property (
    cap_mode && I_OUTPUT_CTRL == `PTC_IO_NONE |-> !cap_fire)
    else $error("capture with edge select none");
  a_cap_clear: assert property (
    clr_hit && !run_rise |=> cnt_ff == '0)
    else $error("capture clear did not zero counter");
  a_cap_no_out: assert property (
    cap_mode |=> O_TIMER_OUT_OE_N && !O_TIMER_OUT)
    else $error("output driven in capture mode");
  a_run_hold: assert property (
    !run_ff && !run_rise ##1 !run_rise && !clr_hit
    |-> cnt_ff == $past(cnt_ff))
    else $error("counter moved while stopped");

endmodule // ptc_timer

// ### verification/ptc_pin_model.sv
`timescale 1ns/1ns

module ptc_pin_model (
  // Clock
  input wire logic i_clock,
  // Requested line and level
  input wire logic [1:0] i_sel,
  input wire logic i_level,
  // Lines into the timer
  output logic o_ext_clock_pin,
  output logic o_capture_pin,
  output logic o_comparator_signal
);
  //******************************************************************
  // Line drive
  //******************************************************************
  initial begin
    o_ext_clock_pin = 1'b0;
    o_capture_pin = 1'b0;
    o_comparator_signal = 1'b0;
  end

  // Lines move away from the sampling edge and hold for many clocks
  always @(posedge i_clock) begin
    #7;
    case (i_sel)
      2'h0: o_capture_pin = i_level;
      2'h1: o_ext_clock_pin = i_level;
      default: o_comparator_signal = i_level;
    endcase
  end
endmodule // ptc_pin_model

// ### verification/periodic_timer_pwm_pulse_capture_test.sv
`timescale 1ns/1ns

module periodic_timer_pwm_pulse_capture_test;
  typedef struct {
    logic [9:0] p;
    logic [9:0] a;
    logic [1:0] io;
    logic pl;
    logic oc;
    logic cc;
    logic [10:0] hi;
    logic [10:0] len;
  } ptc_row_t;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic tick = 1'b1;
  ptc_pkg::ptc_mode_t mode = ptc_pkg::PTC_CAPTURE;
  logic [1:0] octl = 2'h0;
  logic run_wr = 1'b0;
  logic run_wd = 1'b0;
  logic ccs = 1'b0;
  logic pol = 1'b0;
  logic ocl = 1'b1;
  logic csel = 1'b0;
  logic [1:0] isel = 2'h0;
  logic [1:0] tclr = 2'h0;
  logic [9:0] per = 10'h0;
  logic a_wr = 1'b0;
  logic b_wr = 1'b0;
  logic [9:0] wdata = 10'h0;
  logic [1:0] pin_sel = 2'h0;
  logic pin_lvl = 1'b0;
  logic ext_pin, cap_pin, cmp_sig, run, lvl_flag, int_a, int_p, tout, toe_n;
  logic [9:0] cnt, ca, cb, c0;
  int num_errors = 0;
  int cmp_count = 0;
  int n_run, n_out, n_int, len, hi;
  bit got;
  ptc_row_t rows[10] = '{
    '{10'h8, 10'h2, 2'h2, 1'b0, 1'b1, 1'b0, 11'h2, 11'h8},
    '{10'h8, 10'h8, 2'h2, 1'b0, 1'b1, 1'b1, 11'h8, 11'h8},
    '{10'h8, 10'h9, 2'h2, 1'b0, 1'b1, 1'b0, 11'h8, 11'h8},
    '{10'h5, 10'h0, 2'h2, 1'b0, 1'b1, 1'b0, 11'h0, 11'h5},
    '{10'h8, 10'h2, 2'h0, 1'b0, 1'b1, 1'b0, 11'h0, 11'h8},
    '{10'h8, 10'h2, 2'h1, 1'b0, 1'b1, 1'b0, 11'h8, 11'h8},
    '{10'h8, 10'h2, 2'h2, 1'b1, 1'b1, 1'b0, 11'h6, 11'h8},
    '{10'h8, 10'h2, 2'h2, 1'b0, 1'b0, 1'b0, 11'h6, 11'h8},
    '{10'h0, 10'h3, 2'h2, 1'b0, 1'b1, 1'b0, 11'h3, 11'h400},
    '{10'h3ff, 10'h1, 2'h2, 1'b0, 1'b1, 1'b0, 11'h1, 11'h3ff}
  };

  ptc_timer #(.IS_TIMER0(1'b1)) i_dut (.I_CLOCK(clock), .I_RESETN(resetn),
    .I_TIMER_TICK(tick), .I_MODE_SELECT(mode), .I_OUTPUT_CTRL(octl),
    .I_COUNTER_RUN_WR(run_wr), .I_COUNTER_RUN_WDATA(run_wd),
    .I_COUNTER_CLEAR_SELECT(ccs), .I_OUTPUT_INITIAL_LEVEL(ocl),
    .I_OUTPUT_POLARITY(pol), .I_CAPTURE_SOURCE_SELECT(csel),
    .I_INPUT_SOURCE_SELECT(isel), .I_CAPTURE_CLEAR(tclr),
    .I_PERIOD_COMPARE_VALUE(per), .I_COMPARE_A_WR(a_wr),
    .I_COMPARE_B_WR(b_wr), .I_COMPARE_WDATA(wdata),
    .I_EXT_TIMER_CLOCK_PIN(ext_pin), .I_CAPTURE_INPUT_PIN(cap_pin),
    .I_COMPARATOR_CAPTURE_SIGNAL(cmp_sig), .O_COUNTER_RUN(run),
    .O_COUNTER_VALUE(cnt), .O_COMPARE_A_VALUE(ca), .O_COMPARE_B_VALUE(cb),
    .O_CAPTURE_LEVEL_FLAG(lvl_flag), .O_INT_A(int_a), .O_INT_P(int_p),
    .O_TIMER_OUT(tout), .O_TIMER_OUT_OE_N(toe_n));

  ptc_pin_model i_pins (.i_clock(clock), .i_sel(pin_sel), .i_level(pin_lvl),
    .o_ext_clock_pin(ext_pin), .o_capture_pin(cap_pin),
    .o_comparator_signal(cmp_sig));

  always #20 clock = ~clock;

  //******************************************************************
  // Tasks
  //******************************************************************
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic pulse_wr(input int which, input logic [9:0] v);
    @(posedge clock);
    run_wr <= (which == 0);
    a_wr <= (which == 1);
    b_wr <= (which == 2);
    run_wd <= v[0];
    wdata <= v;
    @(posedge clock);
    run_wr <= 1'b0;
    a_wr <= 1'b0;
    b_wr <= 1'b0;
  endtask

  task automatic wait_int(input bit use_p, input int lim, input bit must);
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      @(posedge clock);
      got = use_p ? (int_p === 1'b1) : (int_a === 1'b1);
    end
    if (must && !got) begin
      num_errors++;
      $display("Timed out waiting for an interrupt at %0t", $time);
      stop_test();
    end
  endtask

  // Cycles and output-high count between two period interrupts
  task automatic period_len;
    wait_int(1'b1, 1100, 1'b1);
    len = 0;
    hi = 0;
    got = 1'b0;
    while (!got && len < 1100) begin
      @(posedge clock);
      len++;
      hi += int'(tout === 1'b1);
      got = int_p === 1'b1;
    end
    if (!got) begin
      num_errors++;
      $display("Timed out measuring a period at %0t", $time);
      stop_test();
    end
  endtask

  task automatic pulse_count;
    n_run = 0;
    n_out = 0;
    n_int = 0;
    repeat (40) begin
      @(posedge clock);
      n_run += int'(run === 1'b1);
      n_out += int'(tout === 1'b1);
      n_int += int'(int_a === 1'b1);
    end
    check(11'(n_out), 11'(n_run));
    check(11'(n_int), 11'h1);
    check(11'(n_run >= 6 && n_run <= 9), 11'h1);
  endtask

  task automatic cap_edge(input logic [1:0] line, input logic lvl,
                          input bit exp_int, input bit exp_b);
    pulse_wr(1, 10'h3ff);
    pulse_wr(2, 10'h3ff);
    @(posedge clock);
    c0 = cnt;
    pin_sel <= line;
    pin_lvl <= lvl;
    wait_int(1'b0, 8, 1'b0);
    check(11'(got), 11'(exp_int));
    if (got) begin
      check(11'(exp_b ? ca : cb), 11'h3ff);
      check(11'(10'((exp_b ? cb : ca) - c0) <= 10'h5), 11'h1);
      check(11'(lvl_flag), 11'(lvl));
    end
    repeat (4) @(posedge clock);
  endtask

  //******************************************************************
  // Sequence
  //******************************************************************
  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    check(11'({run, int_a, int_p, tout, toe_n}), 11'h1);
    check(11'(cnt | ca | cb), 11'h0);
    foreach (rows[k]) begin
      pulse_wr(0, 10'h0);
      mode <= ptc_pkg::PTC_PWM;
      per <= rows[k].p;
      octl <= rows[k].io;
      pol <= rows[k].pl;
      ocl <= rows[k].oc;
      ccs <= rows[k].cc;
      pulse_wr(1, rows[k].a);
      pulse_wr(0, 10'h1);
      period_len();
      period_len();
      check(11'(len), rows[k].len);
      check(11'(hi), rows[k].hi);
      check(11'(toe_n), 11'h0);
    end
    pulse_wr(0, 10'h0);
    pol <= 1'b0;
    octl <= 2'h3;
    pulse_wr(1, 10'h6);
    pulse_wr(0, 10'h1);
    pulse_count();
    c0 = cnt;
    repeat (5) @(posedge clock);
    check(11'(cnt), 11'(c0));
    check(11'(cnt != 10'h0), 11'h1);
    @(posedge clock);
    pin_sel <= 2'h1;
    pin_lvl <= 1'b1;
    pulse_count();
    pin_lvl <= 1'b0;
    pulse_wr(1, 10'h12c);
    pulse_wr(0, 10'h1);
    repeat (5) @(posedge clock);
    pulse_wr(0, 10'h0);
    repeat (3) @(posedge clock);
    check(11'({run, tout}), 11'h0);
    repeat (4) @(posedge clock);
    mode <= ptc_pkg::PTC_CAPTURE;
    octl <= 2'h0;
    per <= 10'h0;
    pulse_wr(0, 10'h1);
    cap_edge(2'h0, 1'b1, 1'b1, 1'b0);
    check(11'(toe_n), 11'h1);
    cap_edge(2'h0, 1'b0, 1'b0, 1'b0);
    octl <= 2'h1;
    cap_edge(2'h0, 1'b1, 1'b0, 1'b0);
    cap_edge(2'h0, 1'b0, 1'b1, 1'b0);
    octl <= 2'h2;
    cap_edge(2'h0, 1'b1, 1'b1, 1'b0);
    cap_edge(2'h0, 1'b0, 1'b1, 1'b0);
    octl <= 2'h3;
    cap_edge(2'h0, 1'b1, 1'b0, 1'b0);
    c0 = cnt;
    @(posedge clock);
    check(11'(cnt), 11'(c0 + 10'h1));
    cap_edge(2'h0, 1'b0, 1'b0, 1'b0);
    octl <= 2'h2;
    tclr <= 2'h1;
    cap_edge(2'h0, 1'b1, 1'b1, 1'b0);
    check(11'(cnt < 10'ha), 11'h1);
    cap_edge(2'h0, 1'b0, 1'b1, 1'b1);
    tclr <= 2'h3;
    cap_edge(2'h0, 1'b1, 1'b1, 1'b0);
    check(11'(cnt < 10'ha), 11'h1);
    tclr <= 2'h2;
    cap_edge(2'h0, 1'b0, 1'b1, 1'b1);
    check(11'(cnt < 10'ha), 11'h1);
    tclr <= 2'h0;
    octl <= 2'h0;
    csel <= 1'b1;
    cap_edge(2'h1, 1'b1, 1'b1, 1'b0);
    cap_edge(2'h0, 1'b1, 1'b0, 1'b0);
    cap_edge(2'h1, 1'b0, 1'b0, 1'b0);
    cap_edge(2'h0, 1'b0, 1'b0, 1'b0);
    csel <= 1'b0;
    isel <= 2'h1;
    cap_edge(2'h2, 1'b1, 1'b1, 1'b0);
    cap_edge(2'h0, 1'b1, 1'b0, 1'b0);
    per <= 10'h14;
    period_len();
    check(11'(len), 11'h14);
    per <= 10'h0;
    period_len();
    period_len();
    check(11'(len), 11'h400);
    @(posedge clock);
    tick <= 1'b0;
    repeat (2) @(posedge clock);
    c0 = cnt;
    repeat (4) @(posedge clock);
    check(11'(cnt), 11'(c0));
    tick <= 1'b1;
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    check({run, cnt}, 11'h0);
    check(11'(toe_n), 11'h1);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    check(11'({run, int_a, int_p, tout, toe_n}), 11'h1);
    check(11'(cnt), 11'h0);
    stop_test();
  end
endmodule // periodic_timer_pwm_pulse_capture_test
